/* File: hw/serdes_link_ctrl.sv */
`timescale 1ns/10ps
module serdes_link_ctrl
  import serdes_link_pkg::*;
#(
  parameter int unsigned LOCK_TIMEOUT_CYC = RX_LOCK_TIME_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic tx_ref_clock_in,
  input wire logic [DATA_W-1:0] tx_data_in,
  output logic tx_serial_out,
  output logic tx_serial_oe_out,
  input wire logic serial_in,
  output logic [DATA_W-1:0] rx_par_out,
  output logic rx_par_oe_out,
  output logic rx_clk_out,
  output logic rx_clk_oe_out,
  output logic rx_lock_out,
  output logic rx_lock_oe_out,
  output logic irq_out
);
  localparam logic [TO_W-1:0] TO_MAX = TO_W'(LOCK_TIMEOUT_CYC);

  tx_frame_if frame_if ();

  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] irq_sts_q, irq_sts_d, irq_en_q;
  logic [31:0] prdata_q;
  logic [7:0] err_cnt_q;

  // register bus decode
  logic acc;
  logic hit_ctrl, hit_stat, hit_sts, hit_clr, hit_en, hit_data, hit_err;
  logic mapped;
  logic wr;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] rd_mux;

  assign acc = psel_in & penable_in;
  assign hit_ctrl = (paddr_in == OFF_CTRL);
  assign hit_stat = (paddr_in == OFF_STATUS);
  assign hit_sts = (paddr_in == OFF_IRQ_STS);
  assign hit_clr = (paddr_in == OFF_IRQ_CLR);
  assign hit_en = (paddr_in == OFF_IRQ_EN);
  assign hit_data = (paddr_in == OFF_RX_DATA);
  assign hit_err = (paddr_in == OFF_ERR_CNT);
  assign mapped = hit_ctrl | hit_stat | hit_sts | hit_clr | hit_en | hit_data | hit_err;
  assign wr = acc & pwrite_in & mapped;
  assign irq_clr = (wr & hit_clr) ? pwdata_in[IRQ_W-1:0] : '0;

  // control fields
  logic tx_edge_sel, tx_powerdown_n, tx_out_enable;
  logic rx_edge_sel, rx_enable, rx_powerdown_n;

  assign tx_edge_sel = ctrl_q[C_TX_EDGE];
  assign tx_powerdown_n = ctrl_q[C_TX_PD_N];
  assign tx_out_enable = ctrl_q[C_TX_OE];
  assign rx_edge_sel = ctrl_q[C_RX_EDGE];
  assign rx_enable = ctrl_q[C_RX_EN];
  assign rx_powerdown_n = ctrl_q[C_RX_PD_N];

  // transmit capture
  logic ref_q;
  logic ref_rise, ref_fall, tx_strobe;
  logic tx_pll_on_q;
  logic [DATA_W-1:0] tx_word_q;
  logic tx_valid_q;
  logic tx_drive_q;

  assign ref_rise = tx_ref_clock_in & ~ref_q;
  assign ref_fall = ~tx_ref_clock_in & ref_q;
  assign tx_strobe = tx_edge_sel ? ref_rise : ref_fall;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= tx_ref_clock_in;
    end
  end

  // pll runs only from reference edges and stops in standby
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pll_on_q <= 1'b0;
    end else begin
      tx_pll_on_q <= tx_powerdown_n & (tx_pll_on_q | ref_rise | ref_fall);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_word_q <= '0;
      tx_valid_q <= 1'b0;
    end else if (!tx_powerdown_n) begin
      tx_valid_q <= 1'b0;
    end else if (tx_strobe) begin
      tx_word_q <= tx_data_in;
      tx_valid_q <= 1'b1;
    end
  end

  // enable only gates the driver; the pll stays up
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_drive_q <= 1'b0;
    end else begin
      tx_drive_q <= tx_pll_on_q & tx_out_enable;
    end
  end

  assign frame_if.word = tx_word_q;
  assign frame_if.word_valid = tx_valid_q;
  assign frame_if.pll_on = tx_pll_on_q;

  tx_serializer u_ser (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .link(frame_if)
  );

  assign tx_serial_out = frame_if.serial_bit;
  assign tx_serial_oe_out = tx_drive_q;

  // receive alignment
  rx_state_t st_q, st_d;
  logic [FRAME_BITS-1:0] win_q;
  logic [4:0] ph_q, ph_d;
  logic [2:0] good_q, good_d;
  logic hdr_ok, boundary, locked;
  logic [DATA_W-1:0] rx_word_q;
  logic word_ev, gain_ev, loss_ev, tmo_ev, err_ev;
  logic [TO_W-1:0] to_cnt_q;

  assign hdr_ok = win_q[CLK_HI_BIT] & ~win_q[CLK_LO_BIT];
  assign boundary = (ph_q == FRAME_LAST);
  assign locked = (st_q == RX_LOCKED);

  always_comb begin
    st_d = st_q;
    ph_d = boundary ? PH_RISE : ph_q + 5'h01;
    good_d = good_q;
    case (st_q)
      RX_HUNT: begin
        if (hdr_ok) begin
          st_d = RX_TRACK;
          ph_d = PH_RISE;
          good_d = '0;
        end
      end
      RX_TRACK: begin
        if (boundary) begin
          if (!hdr_ok) begin
            st_d = RX_HUNT;
          end else if (good_q == LOCK_FRAMES - 3'h1) begin
            st_d = RX_LOCKED;
          end else begin
            good_d = good_q + 3'h1;
          end
        end
      end
      RX_LOCKED: begin
        // a silent or released line shows no clock bits and drops lock
        if (boundary && !hdr_ok) begin
          st_d = RX_HUNT;
        end
      end
      default: st_d = RX_HUNT;
    endcase
    if (!rx_powerdown_n) begin
      st_d = RX_HUNT;
      ph_d = PH_RISE;
      good_d = '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= RX_HUNT;
      ph_q <= PH_RISE;
      good_q <= '0;
      win_q <= '0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      good_q <= good_d;
      win_q <= rx_powerdown_n ? {win_q[FRAME_BITS-2:0], serial_in} : '0;
    end
  end

  assign word_ev = locked & boundary & hdr_ok;
  assign err_ev = locked & boundary & ~hdr_ok;
  assign gain_ev = (st_d == RX_LOCKED) & ~locked;
  assign loss_ev = locked & (st_d != RX_LOCKED);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word_q <= '0;
    end else if (word_ev) begin
      rx_word_q <= win_q[DATA_W-1:0] ^ {DATA_W{win_q[INV_BIT]}};
    end
  end

  // counts only while powered and not locked (hunting or tracking); restarts on each power-up
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      to_cnt_q <= '0;
    end else if (!rx_powerdown_n || locked) begin
      to_cnt_q <= '0;
    end else if (to_cnt_q != TO_MAX) begin
      to_cnt_q <= to_cnt_q + 1'b1;
    end
  end

  assign tmo_ev = rx_powerdown_n & ~locked & (to_cnt_q == TO_MAX - 1'b1);

  // recovered clock: high for the first half of each frame
  logic rclk_q;
  logic [4:0] launch_ph;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= locked & (ph_q < PH_HALF);
    end
  end

  assign launch_ph = rx_edge_sel ? PH_RISE : PH_HALF;

  // groups launch one cycle apart to spread output switching
  genvar g;
  generate
    for (g = 0; g < N_GROUPS; g++) begin : grp
      logic [GROUP_W-1:0] par_q;
      logic go;
      assign go = locked & (ph_q == launch_ph + 5'(g));
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          par_q <= '0;
        end else if (go) begin
          par_q <= rx_word_q[g*GROUP_W +: GROUP_W];
        end
      end
      assign rx_par_out[g*GROUP_W +: GROUP_W] = par_q;
    end
  endgenerate

  assign rx_clk_out = rclk_q;
  assign rx_par_oe_out = rx_powerdown_n & rx_enable & locked;
  assign rx_clk_oe_out = rx_powerdown_n & rx_enable & locked;
  assign rx_lock_out = locked;
  assign rx_lock_oe_out = rx_powerdown_n;

  // interrupts; a new event beats a clear in the same cycle
  logic [IRQ_W-1:0] ev;

  assign ev = {tmo_ev, word_ev, loss_ev, gain_ev};
  assign irq_sts_d = (irq_sts_q & ~irq_clr) | ev;
  assign irq_out = |(irq_sts_q & irq_en_q);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= irq_sts_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RESET;
      irq_en_q <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= pwdata_in[CTRL_W-1:0];
      end
      if (wr && hit_en) begin
        irq_en_q <= pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // saturating; any write clears it, an error in that cycle still counts
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_cnt_q <= '0;
    end else if (wr && hit_err) begin
      err_cnt_q <= {7'h00, err_ev};
    end else if (err_ev && err_cnt_q != 8'hff) begin
      err_cnt_q <= err_cnt_q + 8'h01;
    end
  end

  // read data
  logic [STAT_W-1:0] status;

  assign status = {frame_if.frame_active, tx_drive_q, tx_pll_on_q, locked};
  assign rd_mux = hit_ctrl ? {26'h0, ctrl_q} :
                  hit_stat ? {28'h0, status} :
                  hit_sts ? {28'h0, irq_sts_q} :
                  hit_en ? {28'h0, irq_en_q} :
                  hit_data ? {8'h00, rx_word_q} :
                  hit_err ? {24'h0, err_cnt_q} : 32'h0;

  // read data is latched in the setup cycle, so pready needs no wait
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_q <= '0;
    end else if (psel_in && !penable_in) begin
      prdata_q <= pwrite_in ? 32'h0 : rd_mux;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = acc & ~mapped;
endmodule

/* File: hw/serdes_link_pkg.sv */
package serdes_link_pkg;
  localparam int DATA_W = 24;
  localparam int GROUP_W = 8;
  localparam int N_GROUPS = 3;
  localparam int FRAME_BITS = 27;
  localparam int CLK_HI_BIT = 26;
  localparam int CLK_LO_BIT = 25;
  localparam int INV_BIT = 24;
  localparam logic [4:0] FRAME_LAST = 5'h1a;
  localparam logic [4:0] PH_RISE = 5'h00;
  localparam logic [4:0] PH_HALF = 5'h0e;
  localparam logic [4:0] BAL_ONES = 5'h0c;
  localparam logic [2:0] LOCK_FRAMES = 3'h4;

  localparam int CLK_MHZ = 125;
  localparam int RX_LOCK_TIME_MS = 12;
  localparam int RX_LOCK_TIME_CYC = RX_LOCK_TIME_MS * CLK_MHZ * 1000;
  localparam int TO_W = 21;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STS = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_RX_DATA = 8'h14;
  localparam logic [7:0] OFF_ERR_CNT = 8'h18;

  localparam int CTRL_W = 6;
  localparam int C_TX_EDGE = 0;
  localparam int C_TX_PD_N = 1;
  localparam int C_TX_OE = 2;
  localparam int C_RX_EDGE = 3;
  localparam int C_RX_EN = 4;
  localparam int C_RX_PD_N = 5;
  localparam logic [5:0] CTRL_RESET = 6'h09;

  localparam int STAT_W = 4;
  localparam int IRQ_W = 4;
  localparam int I_GAIN = 0;
  localparam int I_LOSS = 1;
  localparam int I_WORD = 2;
  localparam int I_TMO = 3;

  typedef enum {RX_HUNT, RX_TRACK, RX_LOCKED} rx_state_t;
  typedef enum {TX_IDLE, TX_SEND} tx_state_t;
endpackage

/* File: hw/tx_frame_if.sv */
`timescale 1ns/10ps
interface tx_frame_if
  import serdes_link_pkg::*;
  ();
  logic [DATA_W-1:0] word;
  logic word_valid;
  logic pll_on;
  logic serial_bit;
  logic frame_active;
  modport cap (output word, output word_valid, output pll_on, input serial_bit, input frame_active);
  modport ser (input word, input word_valid, input pll_on, output serial_bit, output frame_active);
endinterface

/* File: hw/tx_serializer.sv */
`timescale 1ns/10ps
module tx_serializer
  import serdes_link_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  tx_frame_if.ser link
);
  tx_state_t st_q, st_d;
  logic [FRAME_BITS-1:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic rd_pos_q, rd_pos_d;
  logic [4:0] ones;
  logic inv;
  logic [4:0] sent_ones;
  logic [FRAME_BITS-1:0] frame;

  // invert when the word would push running disparity further the same way
  assign ones = 5'($countones(link.word));
  assign inv = rd_pos_q ? (ones > BAL_ONES) : (ones < BAL_ONES);
  assign sent_ones = inv ? 5'(DATA_W) - ones : ones;
  assign frame = {1'b1, 1'b0, inv, link.word ^ {DATA_W{inv}}};

  // idle line repeats the last word so the far end keeps its lock
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rd_pos_d = rd_pos_q;
    if (!link.pll_on) begin
      st_d = TX_IDLE;
      cnt_d = '0;
    end else begin
      case (st_q)
        TX_IDLE: begin
          if (link.word_valid) begin
            st_d = TX_SEND;
            sh_d = frame;
            cnt_d = '0;
            rd_pos_d = (sent_ones == BAL_ONES) ? rd_pos_q : (sent_ones > BAL_ONES);
          end
        end
        TX_SEND: begin
          if (cnt_q == FRAME_LAST) begin
            sh_d = frame;
            cnt_d = '0;
            rd_pos_d = (sent_ones == BAL_ONES) ? rd_pos_q : (sent_ones > BAL_ONES);
          end else begin
            sh_d = {sh_q[FRAME_BITS-2:0], 1'b0};
            cnt_d = cnt_q + 5'h01;
          end
        end
        default: st_d = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= TX_IDLE;
      sh_q <= '0;
      cnt_q <= '0;
      rd_pos_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rd_pos_q <= rd_pos_d;
    end
  end

  assign link.serial_bit = sh_q[CLK_HI_BIT];
  assign link.frame_active = (st_q == TX_SEND);
endmodule

/* File: verif/link_partner.sv */
`timescale 1ns/10ps
module link_partner (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic tx_serial_in,
  input wire logic tx_serial_oe_in,
  output logic serial_out
);
  logic idle_q;
  // released line toggles so a stale bit never looks like a steady header
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= ~idle_q;
    end
  end
  assign serial_out = tx_serial_oe_in ? tx_serial_in : idle_q;
endmodule

/* File: verif/serdes_link_ctrl_props.sv */
`timescale 1ns/10ps
module serdes_link_ctrl_props
  import serdes_link_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic tx_serial_oe_out,
  input wire logic rx_par_oe_out,
  input wire logic rx_clk_out,
  input wire logic rx_clk_oe_out,
  input wire logic rx_lock_out,
  input wire logic rx_lock_oe_out,
  input wire logic irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire acc = psel_in && penable_in;
  wire wr_ctrl = acc && pwrite_in && paddr_in == OFF_CTRL;
  wire wr_en0 = acc && pwrite_in && paddr_in == OFF_IRQ_EN && pwdata_in[3:0] == 4'h0;
  sequence s_clk_high;
    rx_clk_out[*7] ##1 rx_clk_out[*7];
  endsequence
  sequence s_rx_off;
    !rx_lock_oe_out ##1 (!rx_lock_out && !rx_par_oe_out);
  endsequence
  property p_ready;
    acc |-> pready_out;
  endproperty
  property p_unmapped;
    acc && paddr_in > OFF_ERR_CNT |-> pslverr_out;
  endproperty
  property p_mapped;
    acc && paddr_in == OFF_CTRL |-> !pslverr_out;
  endproperty
  property p_lock_gate;
    rx_par_oe_out |-> rx_lock_out && rx_lock_oe_out;
  endproperty
  property p_clk_oe;
    rx_clk_oe_out == rx_par_oe_out;
  endproperty
  property p_tx_off;
    wr_ctrl && !pwdata_in[C_TX_OE] |=> ##1 !tx_serial_oe_out;
  endproperty
  property p_tx_pd;
    // pll flag drops first, the driver enable follows one cycle later
    wr_ctrl && !pwdata_in[C_TX_PD_N] |=> ##2 !tx_serial_oe_out;
  endproperty
  property p_rx_en;
    wr_ctrl && !pwdata_in[C_RX_EN] |=> !rx_par_oe_out && !rx_clk_oe_out;
  endproperty
  property p_rx_pd;
    wr_ctrl && !pwdata_in[C_RX_PD_N] |=> s_rx_off;
  endproperty
  // a forced re-hunt may cut a clock phase short, so only judge while powered
  property p_rclk;
    @(posedge core_clk_in) disable iff (!rst_n_in || !rx_lock_oe_out)
      $rose(rx_clk_out) && rx_clk_oe_out |-> s_clk_high ##1 !rx_clk_out;
  endproperty
  property p_irq_off;
    wr_en0 |=> ##1 !irq_out;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
  a_mapped: assert property (p_mapped) else $error("error on mapped access");
  a_lock_gate: assert property (p_lock_gate) else $error("outputs driven while unlocked");
  a_clk_oe: assert property (p_clk_oe) else $error("clock and data enables differ");
  a_tx_off: assert property (p_tx_off) else $error("serial out driven while disabled");
  a_tx_pd: assert property (p_tx_pd) else $error("serial out driven in standby");
  a_rx_en: assert property (p_rx_en) else $error("parallel out driven while disabled");
  a_rx_pd: assert property (p_rx_pd) else $error("lock flag driven in standby");
  a_rclk: assert property (p_rclk) else $error("recovered clock high time wrong");
  a_irq_off: assert property (p_irq_off) else $error("irq high with all masked");
endmodule

bind serdes_link_ctrl serdes_link_ctrl_props i_props (.core_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .tx_serial_oe_out, .rx_par_oe_out, .rx_clk_out,
  .rx_clk_oe_out, .rx_lock_out, .rx_lock_oe_out, .irq_out);

/* File: verif/tb_serdes_link_ctrl.sv */
`timescale 1ns/10ps
module tb_serdes_link_ctrl;
  import serdes_link_pkg::*;
`define CHK(NM, EX, GT) begin cmp_count++; if ((GT) !== (EX)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", NM, EX, GT); end end
  int bad_count = 0;
  int cmp_count = 0;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic tx_ref_clock_in = 1'b0;
  logic [DATA_W-1:0] tx_data_in = '0;
  logic [31:0] prdata_out;
  logic [DATA_W-1:0] rx_par_out;
  logic pready_out, pslverr_out, tx_serial_out, tx_serial_oe_out, serial_in;
  logic rx_par_oe_out, rx_clk_out, rx_clk_oe_out, rx_lock_out, rx_lock_oe_out, irq_out;
  logic [31:0] rq;
  logic re;

  always #4 core_clk_in = ~core_clk_in;

  // short lock timeout keeps the timeout interrupt reachable in a brief run
  serdes_link_ctrl #(.LOCK_TIMEOUT_CYC(400)) i_serdes_link_ctrl (.core_clk_in, .rst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_ref_clock_in, .tx_data_in,
    .tx_serial_out, .tx_serial_oe_out, .serial_in, .rx_par_out, .rx_par_oe_out, .rx_clk_out, .rx_clk_oe_out,
    .rx_lock_out, .rx_lock_oe_out, .irq_out);
  link_partner i_link_partner (.core_clk_in, .rst_n_in, .tx_serial_in(tx_serial_out),
    .tx_serial_oe_in(tx_serial_oe_out), .serial_out(serial_in));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk_in);
    end
    if (n == 20)
      bad_count++;
    rq = prdata_out;
    re = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // word on the rising strobe, its inverse on the falling one
  task automatic send(input logic [23:0] d);
    tx_data_in <= d;
    repeat (3) @(posedge core_clk_in);
    tx_ref_clock_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    tx_data_in <= ~d;
    repeat (3) @(posedge core_clk_in);
    tx_ref_clock_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic wait_lock();
    int n;
    n = 0;
    while (rx_lock_out !== 1'b1 && n < 500) begin
      n++;
      @(posedge core_clk_in);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    apb(1'b0, OFF_CTRL, '0);
    `CHK("ctrl reset", 32'h9, rq)
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b0, OFF_STATUS, '0);
    `CHK("status reset", 32'h0, rq)
    apb(1'b0, 8'h40, '0);
    `CHK("unmapped", 33'h100000000, {re, rq})
    apb(1'b1, OFF_CTRL, 32'h3f);
    // sync word: its only high-to-low pair is the header, so a repeating frame cannot misalign the hunt
    send(24'h000fff);
    wait_lock();
    `CHK("lock", 1'b1, rx_lock_out)
    send(24'ha5c31e);
    repeat (60) @(posedge core_clk_in);
    apb(1'b0, OFF_RX_DATA, '0);
    `CHK("rx word", 32'ha5c31e, rq)
    `CHK("par out", 25'h1a5c31e, {rx_par_oe_out, rx_par_out})
    apb(1'b0, OFF_STATUS, '0);
    `CHK("status on", 32'hf, rq)
    apb(1'b0, OFF_IRQ_STS, '0);
    `CHK("irq status", 32'h5, rq)
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge core_clk_in);
    `CHK("irq on", 1'b1, irq_out)
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge core_clk_in);
    `CHK("irq masked", 1'b0, irq_out)
    apb(1'b1, OFF_IRQ_CLR, 32'h1);
    apb(1'b0, OFF_IRQ_STS, '0);
    `CHK("irq cleared", 1'b0, rq[0])
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, OFF_CTRL, (e == 1) ? 32'h3f : 32'h36);
      send(24'h5a0ff1);
      // low byte changes once per pass; the recovered clock level tells the launch edge
      @(rx_par_out[7:0]);
      @(negedge core_clk_in);
      `CHK("launch edge", (e == 1) ? 1'b1 : 1'b0, rx_clk_out)
      repeat (90) @(posedge core_clk_in);
      apb(1'b0, OFF_RX_DATA, '0);
      `CHK("edge word", (e == 1) ? 32'h5a0ff1 : 32'ha5f00e, rq)
      `CHK("lock kept", 1'b1, rx_lock_out)
    end
    apb(1'b1, OFF_IRQ_EN, 32'ha);
    apb(1'b1, OFF_CTRL, 32'h3b);
    // the idle toggle may pass for a header at one boundary at most
    repeat (90) @(posedge core_clk_in);
    `CHK("lock lost", 3'b100, {irq_out, rx_lock_out, rx_par_oe_out})
    apb(1'b0, OFF_ERR_CNT, '0);
    `CHK("header misses", 32'h1, rq)
    repeat (450) @(posedge core_clk_in);
    apb(1'b0, OFF_IRQ_STS, '0);
    `CHK("timeout", 32'ha, rq & 32'ha)
    apb(1'b0, OFF_STATUS, '0);
    `CHK("pll kept", 32'ha, rq)
    apb(1'b1, OFF_IRQ_CLR, 32'hf);
    apb(1'b1, OFF_CTRL, 32'h3f);
    wait_lock();
    `CHK("relock", 1'b1, rx_lock_out)
    repeat (30) @(posedge core_clk_in);
    apb(1'b0, OFF_RX_DATA, '0);
    `CHK("word after relock", 32'h5a0ff1, rq)
    apb(1'b1, OFF_CTRL, 32'h3d);
    repeat (4) @(posedge core_clk_in);
    `CHK("tx standby", 1'b0, tx_serial_oe_out)
    apb(1'b0, OFF_STATUS, '0);
    `CHK("tx pll off", 2'b00, rq[2:1])
    apb(1'b1, OFF_CTRL, 32'h0d);
    repeat (3) @(posedge core_clk_in);
    `CHK("rx standby", 3'b000, {rx_lock_oe_out, rx_lock_out, rx_par_oe_out})
    summarize();
  end
endmodule
